// >>> hdl/dram_bank_timing_config.sv
// Purpose: Register file and bank decode for upper DRAM banks
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes: Lower banks are not decoded here; bank_hit bits 0 to 5 stay zero
`timescale 1ns/10ps
module dram_bank_timing_config #(
  parameter int NBANK = 8
) (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // AXI write address
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI read address
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Memory access from the controller; part types of banks 6 and 7
  input  wire logic [27:0] mem_addr,
  input  wire logic        mem_req,
  input  wire logic [1:0]  bank6_type,
  input  wire logic [1:0]  bank7_type,
  // Bank decode results
  output logic [NBANK-1:0] bank_hit,
  output logic [3:0]       col_bits,
  output logic [3:0]       t_ras_pre,
  output logic [3:0]       t_row_hold,
  output logic [3:0]       t_col_setup,
  output logic [3:0]       t_col_hold,
  output logic [3:0]       t_cas_pre,
  output logic [3:0]       t_rd_pulse,
  output logic [3:0]       t_wr_pulse,
  output logic             cfg_error,
  // Inactivity and bank controls
  output logic             dram_idle_close,
  output logic [NBANK-1:0] bank_enable,
  output logic [3:0]       pair_wide
);
  // Register storage
  logic [15:0] pair45_timing_reg;  // Timing for banks 4/5
  logic [15:0] bank6_ctrl_reg;     // Bank 6 base/size/cols
  logic [15:0] bank7_ctrl_reg;     // Bank 7 base/size/cols
  logic [15:0] pair67_timing_reg;  // Timing for banks 6/7
  logic [15:0] dram_cfg_one;       // Inactivity timeout
  logic [15:0] dram_cfg_two;       // Enables and pairing
  // AXI holding state
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_idx;
  logic [13:0] s_axi_awaddr_q;  // Captured write address
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        ar_go;
  logic        wr_hit;
  logic        rd_hit;
  logic [15:0] next_rdata;
  logic [11:0] ar_idx;
  // Idle counter
  logic [9:0]  idle_cnt;
  logic [9:0]  idle_limit;
  // Decode helpers
  logic [7:0]  bank6_base_addr;
  logic [7:0]  bank7_base_addr;
  logic [2:0]  bank6_size_code;
  logic [2:0]  bank7_size_code;
  logic [2:0]  bank6_col_width;
  logic [2:0]  bank7_col_width;
  logic        pair67_wide_mode;
  logic [8:0]  span6;
  logic [8:0]  span7;
  logic [8:0]  top6;
  logic [8:0]  top7;
  logic [8:0]  top6_eff;
  logic        in6;
  logic        in7;
  logic [15:0] sel_timing;
  logic        sel_edo;
  logic        sel_bad_cfg;
  logic        timing_bad;

  // Write channels accepted independently; response after both
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign aw_idx        = s_axi_awaddr_q[13:2];

  // Write address/data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      s_axi_awaddr_q <= 14'h0000;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held        <= 1'b1;
        s_axi_awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dram_bank_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? dram_bank_pkg::RESP_OKAY : dram_bank_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Map check for a write index
  always_comb begin
    case (aw_idx)
      dram_bank_pkg::IDX_PAIR45_TIMING, dram_bank_pkg::IDX_BANK6_CTRL,
      dram_bank_pkg::IDX_BANK7_CTRL, dram_bank_pkg::IDX_PAIR67_TIMING,
      dram_bank_pkg::IDX_DRAM_CFG_ONE, dram_bank_pkg::IDX_DRAM_CFG_TWO: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (s[0]) v[7:0] = d[7:0];
    if (s[1]) v[15:8] = d[15:8];
    merge = v & m;
  endfunction

  // Register writes; reset values fix bank enables and pairing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pair45_timing_reg <= dram_bank_pkg::RST_TIMING;
      bank6_ctrl_reg    <= dram_bank_pkg::RST_BANK;
      bank7_ctrl_reg    <= dram_bank_pkg::RST_BANK;
      pair67_timing_reg <= dram_bank_pkg::RST_TIMING;
      dram_cfg_one      <= dram_bank_pkg::RST_CFG_ONE;
      dram_cfg_two      <= dram_bank_pkg::RST_CFG_TWO;
    end else if (clk_en && do_write) begin
      case (aw_idx)
        dram_bank_pkg::IDX_PAIR45_TIMING:
          pair45_timing_reg <= merge(pair45_timing_reg, w_data, w_strb,
                                     dram_bank_pkg::MASK_TIMING);
        dram_bank_pkg::IDX_BANK6_CTRL:
          bank6_ctrl_reg <= merge(bank6_ctrl_reg, w_data, w_strb, dram_bank_pkg::MASK_BANK);
        dram_bank_pkg::IDX_BANK7_CTRL:
          bank7_ctrl_reg <= merge(bank7_ctrl_reg, w_data, w_strb, dram_bank_pkg::MASK_BANK);
        dram_bank_pkg::IDX_PAIR67_TIMING:
          pair67_timing_reg <= merge(pair67_timing_reg, w_data, w_strb,
                                     dram_bank_pkg::MASK_TIMING);
        dram_bank_pkg::IDX_DRAM_CFG_ONE:
          dram_cfg_one <= merge(dram_cfg_one, w_data, w_strb, dram_bank_pkg::MASK_CFG_ONE);
        dram_bank_pkg::IDX_DRAM_CFG_TWO:
          dram_cfg_two <= merge(dram_cfg_two, w_data, w_strb, dram_bank_pkg::MASK_CFG_TWO);
        default: ;
      endcase
    end
  end

  // Read path: one read at a time, answer one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_go         = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = s_axi_araddr[13:2];

  // Read mux
  always_comb begin
    rd_hit = 1'b1;
    case (ar_idx)
      dram_bank_pkg::IDX_PAIR45_TIMING: next_rdata = pair45_timing_reg;
      dram_bank_pkg::IDX_BANK6_CTRL:    next_rdata = bank6_ctrl_reg;
      dram_bank_pkg::IDX_BANK7_CTRL:    next_rdata = bank7_ctrl_reg;
      dram_bank_pkg::IDX_PAIR67_TIMING: next_rdata = pair67_timing_reg;
      dram_bank_pkg::IDX_DRAM_CFG_ONE:  next_rdata = dram_cfg_one;
      dram_bank_pkg::IDX_DRAM_CFG_TWO:  next_rdata = dram_cfg_two;
      default: begin
        next_rdata = 16'h0000;
        rd_hit     = 1'b0;
      end
    endcase
  end

  // Read data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= dram_bank_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (ar_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, next_rdata};
        s_axi_rresp  <= rd_hit ? dram_bank_pkg::RESP_OKAY : dram_bank_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Field extraction
  assign bank6_base_addr  = bank6_ctrl_reg[dram_bank_pkg::BASE_LSB +: 8];
  assign bank7_base_addr  = bank7_ctrl_reg[dram_bank_pkg::BASE_LSB +: 8];
  assign bank6_size_code  = bank6_ctrl_reg[dram_bank_pkg::SIZE_LSB +: 3];
  assign bank7_size_code  = bank7_ctrl_reg[dram_bank_pkg::SIZE_LSB +: 3];
  assign bank6_col_width  = bank6_ctrl_reg[dram_bank_pkg::COLW_LSB +: 3];
  assign bank7_col_width  = bank7_ctrl_reg[dram_bank_pkg::COLW_LSB +: 3];
  assign pair67_wide_mode = dram_cfg_two[dram_bank_pkg::WIDE_LSB + 3];
  assign bank_enable      = dram_cfg_two[NBANK-1:0];
  assign pair_wide        = dram_cfg_two[dram_bank_pkg::WIDE_LSB +: 4];

  // Size in megabytes: 1 << code; paired bank doubles the even size
  assign span6    = 9'h001 << bank6_size_code;
  assign span7    = 9'h001 << bank7_size_code;
  assign top6     = {1'b0, bank6_base_addr} + span6;
  assign top7     = {1'b0, bank7_base_addr} + span7;
  assign top6_eff = pair67_wide_mode ? top6 + span6 : top6;
  // Base compares against address bits 27:20, megabyte granular
  assign in6 = {1'b0, mem_addr[27:20]} >= {1'b0, bank6_base_addr} &&
               {1'b0, mem_addr[27:20]} < top6_eff;
  assign in7 = {1'b0, mem_addr[27:20]} >= {1'b0, bank7_base_addr} &&
               {1'b0, mem_addr[27:20]} < top7;

  // Hit vector: bank 6 serves the whole pair when wide; bank 7 then idle
  always_comb begin
    bank_hit = '0;
    if (mem_req && bank_enable[6] && bank6_size_code != dram_bank_pkg::SIZE_RESERVED)
      bank_hit[6] = in6;
    if (mem_req && bank_enable[7] && !pair67_wide_mode &&
        bank7_size_code != dram_bank_pkg::SIZE_RESERVED && !bank_hit[6])
      bank_hit[7] = in7;
  end

  // Pick timing and column width of the selected bank's pair
  always_comb begin
    sel_timing  = pair45_timing_reg;
    sel_edo     = 1'b1;
    sel_bad_cfg = 1'b0;
    col_bits    = dram_bank_pkg::COLW_BASE;
    if (bank_hit[6]) begin
      sel_timing  = pair67_timing_reg;
      sel_edo     = (bank6_type != 2'h0);
      col_bits    = dram_bank_pkg::COLW_BASE + {1'b0, bank6_col_width};
      sel_bad_cfg = bank6_col_width > dram_bank_pkg::COLW_MAX;
    end else if (bank_hit[7]) begin
      sel_timing  = pair67_timing_reg;
      sel_edo     = (bank7_type != 2'h0);
      col_bits    = dram_bank_pkg::COLW_BASE + {1'b0, bank7_col_width};
      sel_bad_cfg = bank7_col_width > dram_bank_pkg::COLW_MAX;
    end
  end

  // Timing decode of the chosen pair
  dram_timing_decode u_decode (
    .timing        (sel_timing),
    .edo_ok        (sel_edo),
    .ras_pre       (t_ras_pre),
    .row_hold      (t_row_hold),
    .col_setup     (t_col_setup),
    .col_hold      (t_col_hold),
    .cas_pre       (t_cas_pre),
    .rd_pulse      (t_rd_pulse),
    .wr_pulse      (t_wr_pulse),
    .edo_violation (timing_bad)
  );
  assign cfg_error = timing_bad || sel_bad_cfg;

  // Inactivity limit from timeout code; reserved codes act as never
  always_comb begin
    case (dram_cfg_one[dram_bank_pkg::TIMEOUT_LSB +: 3])
      dram_bank_pkg::TO_8:   idle_limit = dram_bank_pkg::CNT_8;
      dram_bank_pkg::TO_32:  idle_limit = dram_bank_pkg::CNT_32;
      dram_bank_pkg::TO_128: idle_limit = dram_bank_pkg::CNT_128;
      dram_bank_pkg::TO_512: idle_limit = dram_bank_pkg::CNT_512;
      default:               idle_limit = 10'h000;
    endcase
  end

  // Idle counter: counts clocks without a request, saturates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_cnt        <= 10'h000;
      dram_idle_close <= 1'b0;
    end else if (clk_en) begin
      if (mem_req) begin
        idle_cnt        <= 10'h000;
        dram_idle_close <= 1'b0;
      end else begin
        if (idle_cnt != 10'h3FF)
          idle_cnt <= idle_cnt + 10'h001;
        if (dram_cfg_one[dram_bank_pkg::TIMEOUT_LSB +: 3] == dram_bank_pkg::TO_NOW)
          dram_idle_close <= 1'b1;
        else if (idle_limit != 10'h000 && idle_cnt + 10'h001 >= idle_limit)
          dram_idle_close <= 1'b1;
        else
          dram_idle_close <= 1'b0;
      end
    end
  end

  // Checks
  a_reset_enables: assert property (@(posedge aclk)
    $rose(aresetn) |-> bank_enable == 8'h01 && pair_wide == 4'h0)
    else $error("bank enables wrong after reset");
  a_idle_eight: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && !mem_req && dram_cfg_one[5:3] == 3'h1 && idle_cnt == 10'h007)
    |=> dram_idle_close)
    else $error("idle close late for 8 clocks");
  a_idle_never: assert property (@(posedge aclk) disable iff (!aresetn)
    dram_cfg_one[5:3] == 3'h0 && $stable(dram_cfg_one) |=> !dram_idle_close)
    else $error("idle close with timeout never");
  a_wide_no_seven: assert property (@(posedge aclk) disable iff (!aresetn)
    pair67_wide_mode |-> !bank_hit[7])
    else $error("odd bank hit while paired");
  a_disabled_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !bank_enable[6] |-> !bank_hit[6])
    else $error("disabled bank selected");
  a_hit_base: assert property (@(posedge aclk) disable iff (!aresetn)
    bank_hit[6] |-> mem_addr[27:20] >= bank6_base_addr)
    else $error("hit below base");
  a_hit_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    bank_hit[6] |-> t_ras_pre == 4'h3 + {1'b0, pair67_timing_reg[2:0]})
    else $error("wrong pair timing");
  a_col_width: assert property (@(posedge aclk) disable iff (!aresetn)
    bank_hit[7] |-> col_bits == 4'h8 + {1'b0, bank7_col_width})
    else $error("column width wrong");
endmodule // dram_bank_timing_config

// >>> shared/dram_bank_pkg.sv
// Purpose: Constants for the upper-bank DRAM timing and placement block
// Assumes: Registers are 16 bits, one per aligned 32-bit AXI word
// Notes: Printed offsets are indexes; byte address is four times the index
package dram_bank_pkg;
  // Register indexes
  localparam logic [11:0] IDX_PAIR45_TIMING = 12'h20A;
  localparam logic [11:0] IDX_BANK6_CTRL    = 12'h20B;
  localparam logic [11:0] IDX_BANK7_CTRL    = 12'h20C;
  localparam logic [11:0] IDX_PAIR67_TIMING = 12'h20D;
  localparam logic [11:0] IDX_DRAM_CFG_ONE  = 12'h20E;
  localparam logic [11:0] IDX_DRAM_CFG_TWO  = 12'h20F;
  // Reset values
  localparam logic [15:0] RST_TIMING   = 16'h3FFF;
  localparam logic [15:0] RST_BANK     = 16'h0000;
  localparam logic [15:0] RST_CFG_ONE  = 16'h0000;
  localparam logic [15:0] RST_CFG_TWO  = 16'h0001;
  // Writable masks (reserved bits read zero)
  localparam logic [15:0] MASK_TIMING  = 16'h3FFF;
  localparam logic [15:0] MASK_BANK    = 16'h7EFF;
  localparam logic [15:0] MASK_CFG_ONE = 16'h01F8;
  localparam logic [15:0] MASK_CFG_TWO = 16'h0FFF;
  // Timing field positions
  localparam int RAS_PRE_LSB = 0;
  localparam int ROW_HOLD_LSB = 3;
  localparam int COL_SETUP_LSB = 5;
  localparam int COL_HOLD_BIT = 7;
  localparam int CAS_PRE_BIT = 8;
  localparam int RD_PULSE_LSB = 9;
  localparam int WR_PULSE_LSB = 12;
  // Bank control field positions
  localparam int BASE_LSB = 0;
  localparam int SIZE_LSB = 9;
  localparam int COLW_LSB = 12;
  // Config field positions
  localparam int TIMEOUT_LSB = 3;
  localparam int WIDE_LSB = 8;
  // Codes
  localparam logic [2:0] SIZE_RESERVED = 3'h7;
  localparam logic [2:0] COLW_MAX      = 3'h4;
  localparam logic [2:0] TO_NEVER = 3'h0;
  localparam logic [2:0] TO_8     = 3'h1;
  localparam logic [2:0] TO_32    = 3'h2;
  localparam logic [2:0] TO_128   = 3'h3;
  localparam logic [2:0] TO_512   = 3'h4;
  localparam logic [2:0] TO_NOW   = 3'h7;
  // Timing counts, in bus clocks
  localparam logic [9:0] CNT_8   = 10'h008;
  localparam logic [9:0] CNT_32  = 10'h020;
  localparam logic [9:0] CNT_128 = 10'h080;
  localparam logic [9:0] CNT_512 = 10'h200;
  // Column width base (code 000 = 8 bits)
  localparam logic [3:0] COLW_BASE = 4'h8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> hdl/dram_timing_decode.sv
// Purpose: Decode one pair's timing word into half-clock counts
// Assumes: Half-clock units, so 1.5T is 3
// Notes: Pure combinational; fields picked from the timing word
`timescale 1ns/10ps
module dram_timing_decode (
  // Timing word and EDO flag
  input  wire logic [15:0] timing,
  input  wire logic        edo_ok,
  // Decoded times in half clocks
  output logic [3:0]       ras_pre,
  output logic [3:0]       row_hold,
  output logic [3:0]       col_setup,
  output logic [3:0]       col_hold,
  output logic [3:0]       cas_pre,
  output logic [3:0]       rd_pulse,
  output logic [3:0]       wr_pulse,
  output logic             edo_violation
);
  // Field mapping
  always_comb begin
    ras_pre   = 4'h3 + {1'b0, timing[dram_bank_pkg::RAS_PRE_LSB +: 3]};
    row_hold  = 4'h1 + {2'b00, timing[dram_bank_pkg::ROW_HOLD_LSB +: 2]};
    col_setup = {2'b00, timing[dram_bank_pkg::COL_SETUP_LSB +: 2]};
    col_hold  = timing[dram_bank_pkg::COL_HOLD_BIT] ? 4'h2 : 4'h1;
    cas_pre   = timing[dram_bank_pkg::CAS_PRE_BIT] ? 4'h2 : 4'h1;
    rd_pulse  = 4'h1 + {1'b0, timing[dram_bank_pkg::RD_PULSE_LSB +: 3]};
    wr_pulse  = 4'h1 + {2'b00, timing[dram_bank_pkg::WR_PULSE_LSB +: 2]};
    // Half-clock pulses only legal on EDO parts
    edo_violation = !edo_ok && (rd_pulse == 4'h1 || wr_pulse == 4'h1);
  end
endmodule // dram_timing_decode

// >>> tb/dram_bank_model.sv
// Purpose: Far-side DRAM part model giving each upper bank's part type
// Assumes: Type codes 00 standard, 01 EDO, 10 burst EDO
// Notes: Reserved type 11 is never presented, so decode sees legal parts
`timescale 1ns/10ps
module dram_bank_model (
  // Clock and part choice
  input  wire logic       aclk,
  input  wire logic [1:0] edo_sel,
  // Part types seen by the decode
  output logic [1:0]      bank6_type,
  output logic [1:0]      bank7_type
);
  // Parts change only at an edge; bank 7 stands in for burst EDO
  always_ff @(posedge aclk) begin
    bank6_type <= edo_sel[0] ? 2'h1 : 2'h0;
    bank7_type <= edo_sel[1] ? 2'h2 : 2'h0;
  end
endmodule // dram_bank_model

// >>> tb/tb_dram_bank_timing_config.sv
// Purpose: Self-checking bench for the upper DRAM bank timing block
// Assumes: AXI4-Lite master; byte address is four times the index
// Notes: Bus answers are checked from queues by a monitor process
`timescale 1ns/10ps
module tb_dram_bank_timing_config;
  // Bus and decode signals
  logic        aclk, aresetn, clk_en, mem_req, cfg_error, dram_idle_close;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, col_bits, pair_wide, t_rp, t_rh, t_cs, t_ch, t_cp, t_rd, t_wr;
  logic [1:0]  bresp, rresp, bank6_type, bank7_type, edo_sel;
  logic [27:0] mem_addr;
  logic [7:0]  bank_hit, bank_enable;
  logic [15:0] w;
  // Bookkeeping
  int          fail_count, comparisons, seed, n, c;
  logic [33:0] rd_q[$];   // Expected {rresp, rdata}
  logic [1:0]  wr_q[$];   // Expected bresp
  logic [15:0] rst_v[6] = '{16'h3FFF, 16'h0000, 16'h0000, 16'h3FFF, 16'h0000, 16'h0001};
  logic [2:0]  to_code[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int          to_cnt[6] = '{600, 8, 32, 128, 512, 1};

  dram_bank_timing_config dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_addr(mem_addr),
    .mem_req(mem_req), .bank6_type(bank6_type), .bank7_type(bank7_type),
    .bank_hit(bank_hit), .col_bits(col_bits), .t_ras_pre(t_rp), .t_row_hold(t_rh),
    .t_col_setup(t_cs), .t_col_hold(t_ch), .t_cas_pre(t_cp), .t_rd_pulse(t_rd),
    .t_wr_pulse(t_wr), .cfg_error(cfg_error), .dram_idle_close(dram_idle_close),
    .bank_enable(bank_enable), .pair_wide(pair_wide)
  );
  dram_bank_model parts (
    .aclk(aclk), .edo_sel(edo_sel), .bank6_type(bank6_type), .bank7_type(bank7_type)
  );

  // Free-running bus clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // One compare point for every result
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Counts, verdict and end of run
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Register write; upper lanes carry junk that must be ignored
  task automatic wr(input logic [11:0] i, input logic [15:0] d,
                    input logic [3:0] s = 4'hF, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    wr_q.push_back(r);
    awaddr <= {i, 2'b00};
    wdata <= {16'hA5A5, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 100) begin
      fail_count++;
      stop_test;
    end
  endtask

  // Register read; expected answer noted before the request
  task automatic rd(input logic [11:0] i, input logic [15:0] d, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    rd_q.push_back({r, 16'h0000, d});
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 100) begin
      fail_count++;
      stop_test;
    end
  endtask

  // Present an access address and look at the settled decode
  task automatic probe(input logic [27:0] a, input logic [7:0] h, input logic [3:0] cb);
    @(posedge aclk);
    mem_addr <= a;
    @(negedge aclk);
    check(bank_hit, h);
    check(col_bits, cb);
  endtask

  // Bus answers, oldest note first
  always @(posedge aclk) begin
    if (bvalid && bready) check(bresp, wr_q.pop_front());
    if (rvalid && rready) check({rresp, rdata}, rd_q.pop_front());
  end

  // Main sequence
  initial begin
    {fail_count, comparisons, seed} = {32'd0, 32'd0, 32'd84};
    {aresetn, awvalid, wvalid, bready, arvalid, rready, mem_req} = 7'h00;
    {clk_en, edo_sel, awaddr, araddr, wdata, wstrb, mem_addr} = {1'b1, 2'h3, 92'h0};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    mem_req <= 1'b1;
    check(bank_enable, 8'h01);
    check(pair_wide, 4'h0);
    for (int k = 0; k < 6; k++) rd(12'h20A + k[11:0], rst_v[k]);
    rd(12'h210, 16'h0000, 2'h2);
    wr(12'h210, 16'h1234, 4'hF, 2'h2);
    wr(12'h20C, 16'hFFFF, 4'h1);
    rd(12'h20C, 16'h00FF);
    wr(12'h20C, 16'hFFFF);
    rd(12'h20C, 16'h7EFF);
    wr(12'h20C, 16'h0080);
    wr(12'h20F, 16'h00C1);
    check(bank_enable, 8'hC1);
    // Every non-reserved size and column code; a 64 MB bank 6 abuts bank 7
    for (int s = 0; s < 7; s++) begin
      c = (s > 4) ? 0 : s;
      wr(12'h20B, {1'b0, c[2:0], s[2:0], 1'b0, 8'h40});
      probe(28'h4000000 + (28'h0100000 << s) - 28'h1, 8'h40, 4'h8 + c[3:0]);
      probe(28'h4000000 + (28'h0100000 << s), (s == 6) ? 8'h80 : 8'h00, 4'h8);
      probe(28'h3FFFFFF, 8'h00, 4'h8);
    end
    wr(12'h20F, 16'h0041);
    probe(28'h8000000, 8'h00, 4'h8);
    wr(12'h20F, 16'h08C1);
    wr(12'h20B, 16'h1040);
    check(pair_wide, 4'h8);
    probe(28'h4100000, 8'h40, 4'h9);
    probe(28'h4200000, 8'h00, 4'h8);
    // Random pair timing words decoded into half clocks
    for (int k = 0; k < 6; k++) begin
      w = 16'($random(seed)) & 16'h3FFF;
      wr(12'h20D, w);
      probe(28'h4000000, 8'h40, 4'h9);
      check(t_rp, w[2:0] + 4'h3);
      check(t_rh, w[4:3] + 4'h1);
      check(t_cs, w[6:5]);
      check(t_ch, w[7] + 4'h1);
      check(t_cp, w[8] + 4'h1);
      check(t_rd, w[11:9] + 4'h1);
      check(t_wr, w[13:12] + 4'h1);
      check(cfg_error, 1'b0);
      w = 16'($random(seed)) & 16'h3FFF;
      wr(12'h20A, w);
      probe(28'h0000000, 8'h00, 4'h8);
      check(t_rp, w[2:0] + 4'h3);
      check(t_wr, w[13:12] + 4'h1);
    end
    // Half-clock pulses refused on standard parts, reserved column code
    edo_sel <= 2'h0;
    wr(12'h20D, 16'h3000);
    probe(28'h4000000, 8'h40, 4'h9);
    check(cfg_error, 1'b1);
    wr(12'h20D, 16'h0E00);
    probe(28'h4000000, 8'h40, 4'h9);
    check(cfg_error, 1'b1);
    edo_sel <= 2'h3;
    wr(12'h20B, 16'h5040);
    probe(28'h4000000, 8'h40, 4'hD);
    check(cfg_error, 1'b1);
    // Every inactivity code but reserved 5 and 6, idle clocks counted after the access ends
    for (int k = 0; k < 6; k++) begin
      wr(12'h20E, {10'h000, to_code[k], 3'h0});
      // Two edges of access so a close left from the last code has dropped
      mem_req <= 1'b1;
      repeat (2) @(posedge aclk);
      mem_req <= 1'b0;
      for (n = 0; n < 600 && dram_idle_close !== 1'b1; n++) @(posedge aclk);
      // Flag is seen one edge after it is set; never runs the loop out
      check(n, (k == 0) ? to_cnt[k] : to_cnt[k] + 1);
    end
    // Frozen clock enable holds the idle count
    wr(12'h20E, 16'h0008);
    mem_req <= 1'b1;
    repeat (2) @(posedge aclk);
    {mem_req, clk_en} <= 2'b00;
    repeat (20) @(posedge aclk);
    check(dram_idle_close, 1'b0);
    clk_en <= 1'b1;
    repeat (9) @(posedge aclk);
    check(dram_idle_close, 1'b1);
    // Mid-run reset restores enables, pairing and timing
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h20F, 16'h0001);
    rd(12'h20D, 16'h3FFF);
    check(bank_enable, 8'h01);
    stop_test;
  end
endmodule // tb_dram_bank_timing_config
